// ==== verilog/mtm_pkg.sv ====
// Constants, register layout and types of the multimode timer module
// Assumes a 32-bit APB slave, one aligned word per register
// Summary of operation
// - Every timer is a 16-bit counter; aux timers chain to the core
// - Each of the three timers selects timer, gated, counter or incremental mode
// - Timer mode counts system clock divided by a programmable prescaler
// - Counter mode counts edges seen on the timer's count/gate pin
// - Gated mode counts prescaled ticks only while the gate pin is active
// - No timer advances more often than once per four clocks
// - Direction set by software, optionally flipped live by the direction pin
// - Incremental mode decodes quadrature A/B pins into steps and direction
// - Core toggle latch inverts on every core overflow or underflow
// - Toggle latch state drives an output pin
// - Toggle latch changes can clock either auxiliary timer
// - Aux timers may instead act as reload or capture register
// - An aux timer in reload or capture role never counts
// - Capture copies the core count into the aux timer on its pin event
// - Reload loads core from aux on pin event or chosen latch transition
// - Two aux reloads on opposite latch transitions alternate, giving free PWM
package mtm_pkg;
   // Counter and prescaler
   localparam int cnt_width = 16;
   localparam int base_log2 = 2;
   localparam int presc_bits = 3;
   localparam int presc_width = 9;
   // Register byte offsets
   localparam logic [7:0] off_ctrl = 8'h00;
   localparam logic [7:0] off_count = 8'h0c;
   localparam logic [7:0] off_status = 8'h18;
   localparam logic [7:0] off_mask = 8'h1c;
   localparam logic [7:0] off_step = 8'h04;
   // Control register fields
   localparam int f_mode = 0;
   localparam int f_run = 2;
   localparam int f_sw_down = 3;
   localparam int f_ext_dir = 4;
   localparam int f_gate_lvl = 5;
   localparam int f_edge = 6;
   localparam int f_presc = 8;
   localparam int f_func = 11;
   localparam int f_tl_out = 11;
   localparam int f_tl_clk = 13;
   localparam int f_ext_trig = 14;
   localparam int f_tl_trans = 15;
   localparam int ctrl_width = 17;
   localparam logic [16:0] ctrl_reset = 17'h00000;
   // Status register fields
   localparam int st_wrap = 0;
   localparam int st_event = 3;
   localparam int st_width = 5;
   localparam logic [4:0] st_reset = 5'h00;
   localparam logic tl_reset = 1'b0;

   typedef enum logic [1:0] {
      mode_timer = 2'b00,
      mode_gated = 2'b01,
      mode_counter = 2'b10,
      mode_incr = 2'b11
   } mtm_mode_type;

   typedef enum logic [1:0] {
      func_basic = 2'b00,
      func_reload = 2'b01,
      func_capture = 2'b10,
      func_spare = 2'b11
   } mtm_func_type;
endpackage

// ==== verilog/mtm_input_cond.sv ====
`timescale 1ns/100ps
// Pin sampler: edge and quadrature decoding for one timer
// Assumes pins synchronous to pclk and a sample strobe every four clocks
module mtm_input_cond (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Sample strobe
   input wire logic sample,
   // Timer pins
   input wire logic count_gate,
   input wire logic direction,
   // Decoded events; rise, fall and quad_step only with sample
   output logic rise,
   output logic fall,
   output logic quad_step,
   output logic quad_down
);
   logic count_gate_q;
   logic direction_q;
   wire a_chg = count_gate ^ count_gate_q;
   wire b_chg = direction ^ direction_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_gate_q <= 1'b0;
         direction_q <= 1'b0;
      end else if (sample) begin
         count_gate_q <= count_gate;
         direction_q <= direction;
      end
   end

   assign rise = sample & a_chg & count_gate;
   assign fall = sample & a_chg & ~count_gate;
   // Both pins moving at once is a sensor fault and is dropped
   assign quad_step = sample & (a_chg ^ b_chg);
   assign quad_down = count_gate_q ^ direction;
endmodule

// ==== verilog/mtm_timer_cell.sv ====
`timescale 1ns/100ps
// One up/down counter with load and wrap detection
// Assumes tick is a one-cycle enable and load has priority
module mtm_timer_cell #(
   parameter int width = mtm_pkg::cnt_width
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic tick,
   input wire logic down,
   input wire logic load,
   input wire logic [width-1:0] load_value,
   // State
   output logic [width-1:0] count,
   output logic wrap
);
   if (width < 2 || width > 32) begin : g_bad
      $error("mtm_timer_cell: width out of range");
   end

   wire at_limit = down ? (count == '0) : (&count);
   assign wrap = tick & at_limit;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= '0;
      end else if (load) begin
         count <= load_value;
      end else if (tick) begin
         count <= down ? count - 1'b1 : count + 1'b1;
      end
   end
endmodule

// ==== verilog/mtm_timer_module.sv ====
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/100ps
// Core timer with toggle latch and two auxiliary timers behind APB
// Assumes pins synchronous to pclk; index 0 core, 1 aux low, 2 aux high
module mtm_timer_module #(
   parameter int width = mtm_pkg::cnt_width
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Timer pins
   input wire logic [2:0] timer_count_gate_input,
   input wire logic [2:0] timer_direction_input,
   // Outputs
   output logic toggle_latch_pin,
   output logic irq
);
   if (width < 2 || width > mtm_pkg::cnt_width) begin : g_bad
      $error("mtm_timer_module: width out of range");
   end

   logic [width-1:0] count [3];
   logic [width-1:0] load_value [3];
   logic [mtm_pkg::ctrl_width-1:0] ctrl [3];
   logic [mtm_pkg::st_width-1:0] status;
   logic [mtm_pkg::st_width-1:0] mask;
   logic [mtm_pkg::presc_width-1:0] presc;
   logic core_tl;
   logic [31:0] next_rdata;
   logic next_err;
   wire [2:0] tick;
   wire [2:0] wrap;
   wire [2:0] load;
   wire [2:0] down;
   wire [2:0] held;
   wire [2:0] rise;
   wire [2:0] fall;
   wire [2:0] qstep;
   wire [2:0] qdown;
   wire [2:0] cap_fire;
   wire [2:0] rl_fire;
   wire [2:0] sw_cnt_wr;
   wire [2:0] wr_ctrl;

   function automatic logic [7:0] reg_off(input logic [7:0] base, input int idx);
      return 8'(base + mtm_pkg::off_step * 8'(idx));
   endfunction

   // Strobe when the low 2+e prescaler bits are all ones
   function automatic logic presc_hit(input logic [mtm_pkg::presc_width-1:0] c,
      input logic [mtm_pkg::presc_bits-1:0] e);
      logic [mtm_pkg::presc_width-1:0] low;
      low = ~({mtm_pkg::presc_width{1'b1}} << (4'(e) + 4'(mtm_pkg::base_log2)));
      return &(c | ~low);
   endfunction

   // Bus decode
   wire setup = psel & ~penable;
   wire wr_fire = psel & penable & pready & pwrite;
   wire wr_status = wr_fire & (paddr == mtm_pkg::off_status);
   wire wr_mask = wr_fire & (paddr == mtm_pkg::off_mask);

   // Base strobe every four clocks
   wire sample = &presc[mtm_pkg::base_log2-1:0];

   // Toggle latch transitions
   wire tl_rise = wrap[0] & ~core_tl;
   wire tl_fall = wrap[0] & core_tl;
   wire next_tl = core_tl ^ wrap[0];

   // Sticky flags: a new event beats a clear in the same cycle
   wire [mtm_pkg::st_width-1:0] st_set = {rl_fire[2:1] | cap_fire[2:1], wrap};
   wire [mtm_pkg::st_width-1:0] st_clr =
      wr_status ? pwdata[mtm_pkg::st_width-1:0] : mtm_pkg::st_reset;
   wire [mtm_pkg::st_width-1:0] next_status = (status & ~st_clr) | st_set;
   wire [mtm_pkg::st_width-1:0] next_mask =
      wr_mask ? pwdata[mtm_pkg::st_width-1:0] : mask;

   always_comb begin
      next_rdata = '0;
      next_err = 1'b0;
      case (paddr)
         reg_off(mtm_pkg::off_ctrl, 0): next_rdata = 32'(ctrl[0]);
         reg_off(mtm_pkg::off_ctrl, 1): next_rdata = 32'(ctrl[1]);
         reg_off(mtm_pkg::off_ctrl, 2): next_rdata = 32'(ctrl[2]);
         reg_off(mtm_pkg::off_count, 0): next_rdata = 32'(count[0]);
         reg_off(mtm_pkg::off_count, 1): next_rdata = 32'(count[1]);
         reg_off(mtm_pkg::off_count, 2): next_rdata = 32'(count[2]);
         mtm_pkg::off_status: next_rdata = 32'({core_tl, status});
         mtm_pkg::off_mask: next_rdata = 32'(mask);
         default: next_err = 1'b1;
      endcase
   end

   // Zero-wait APB answer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= '0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         if (setup) begin
            prdata <= next_rdata;
            pslverr <= next_err;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         presc <= '0;
      end else begin
         presc <= presc + 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= mtm_pkg::st_reset;
         mask <= mtm_pkg::st_reset;
         irq <= 1'b0;
      end else begin
         status <= next_status;
         mask <= next_mask;
         irq <= |(next_status & next_mask);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_tl <= mtm_pkg::tl_reset;
         toggle_latch_pin <= 1'b0;
      end else begin
         core_tl <= next_tl;
         toggle_latch_pin <= ctrl[0][mtm_pkg::f_tl_out] & next_tl;
      end
   end

   for (genvar i = 0; i < 3; i++) begin : g_tmr
      mtm_pkg::mtm_mode_type mode;
      mtm_pkg::mtm_func_type func;
      logic base_tick;
      wire [1:0] edge_sel = ctrl[i][mtm_pkg::f_edge+:2];
      wire [1:0] trans_sel = ctrl[i][mtm_pkg::f_tl_trans+:2];
      wire ev_edge = (edge_sel[0] & rise[i]) | (edge_sel[1] & fall[i]);
      wire presc_tick = presc_hit(presc, ctrl[i][mtm_pkg::f_presc+:mtm_pkg::presc_bits]);
      wire gate_open = timer_count_gate_input[i] == ctrl[i][mtm_pkg::f_gate_lvl];
      wire tl_clk = (i != 0) && ctrl[i][mtm_pkg::f_tl_clk];
      wire sw_down = ctrl[i][mtm_pkg::f_sw_down];
      wire pin_down = ctrl[i][mtm_pkg::f_ext_dir] & timer_direction_input[i];
      wire ext_trig = ctrl[i][mtm_pkg::f_ext_trig] & ev_edge;

      assign mode = mtm_pkg::mtm_mode_type'(ctrl[i][mtm_pkg::f_mode+:2]);
      // Core timer has no second role
      assign func = (i == 0) ? mtm_pkg::func_basic
         : mtm_pkg::mtm_func_type'(ctrl[i][mtm_pkg::f_func+:2]);
      assign wr_ctrl[i] = wr_fire & (paddr == reg_off(mtm_pkg::off_ctrl, i));
      assign sw_cnt_wr[i] = wr_fire & (paddr == reg_off(mtm_pkg::off_count, i));

      always_comb begin
         case (mode)
            mtm_pkg::mode_timer: base_tick = presc_tick;
            mtm_pkg::mode_gated: base_tick = presc_tick & gate_open;
            mtm_pkg::mode_counter: base_tick = tl_clk ? wrap[0] : ev_edge;
            mtm_pkg::mode_incr: base_tick = qstep[i];
            default: base_tick = 1'b0;
         endcase
      end

      assign held[i] = func != mtm_pkg::func_basic;
      assign tick[i] = ctrl[i][mtm_pkg::f_run] & ~held[i] & base_tick;
      // Pin level flips the software direction while running
      assign down[i] = (mode == mtm_pkg::mode_incr) ? qdown[i] ^ sw_down
         : sw_down ^ pin_down;
      assign cap_fire[i] = (func == mtm_pkg::func_capture) & ev_edge;
      assign rl_fire[i] = (func == mtm_pkg::func_reload)
         & (ext_trig | (trans_sel[0] & tl_rise) | (trans_sel[1] & tl_fall));

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            ctrl[i] <= mtm_pkg::ctrl_reset;
         end else if (wr_ctrl[i]) begin
            ctrl[i] <= pwdata[mtm_pkg::ctrl_width-1:0];
         end
      end

      mtm_input_cond u_pins (
         .pclk(pclk),
         .presetn(presetn),
         .sample(sample),
         .count_gate(timer_count_gate_input[i]),
         .direction(timer_direction_input[i]),
         .rise(rise[i]),
         .fall(fall[i]),
         .quad_step(qstep[i]),
         .quad_down(qdown[i])
      );

      mtm_timer_cell #(
         .width(width)
      ) u_cell (
         .pclk(pclk),
         .presetn(presetn),
         .tick(tick[i]),
         .down(down[i]),
         .load(load[i]),
         .load_value(load_value[i]),
         .count(count[i]),
         .wrap(wrap[i])
      );
   end

   // Software write beats reload; aux low beats aux high
   assign load[0] = sw_cnt_wr[0] | rl_fire[1] | rl_fire[2];
   assign load_value[0] = sw_cnt_wr[0] ? pwdata[width-1:0]
      : rl_fire[1] ? count[1] : count[2];

   for (genvar j = 1; j < 3; j++) begin : g_aux
      assign load[j] = sw_cnt_wr[j] | cap_fire[j];
      assign load_value[j] = sw_cnt_wr[j] ? pwdata[width-1:0] : count[0];
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_tick_gap: assert property (tick[0] |=> (!tick[0]) [*3])
      else $error("core timer advanced twice within four clocks");

   a_gate_shut: assert property (
      g_tmr[0].mode == mtm_pkg::mode_gated && !g_tmr[0].gate_open |-> !tick[0])
      else $error("gated core timer counted with gate closed");

   a_tl_flip: assert property (wrap[0] |=> core_tl != $past(core_tl))
      else $error("toggle latch did not invert on wrap");

   a_tl_pin: assert property (
      $past(ctrl[0][mtm_pkg::f_tl_out]) |-> toggle_latch_pin == core_tl)
      else $error("toggle latch pin differs from latch");

   a_up_wrap: assert property (
      tick[0] && !down[0] && (&count[0]) && !load[0] |=> count[0] == '0 ##1 1'b1)
      else $error("up count did not wrap to zero");

   a_down_wrap: assert property (
      tick[0] && down[0] && count[0] == '0 && !load[0] |=> &count[0])
      else $error("down count did not wrap to all ones");

   a_wrap_flag: assert property (
      wrap[1] |=> status[mtm_pkg::st_wrap + 1] && (mask[1] == irq || mask[0] || status[0]
      || (|status[mtm_pkg::st_width-1:2])))
      else $error("aux low wrap not flagged");

   a_aux_still: assert property (held[2] && !load[2] |=> $stable(count[2]))
      else $error("aux high counted while in register role");

   a_capture_copy: assert property (
      cap_fire[1] && !sw_cnt_wr[1] |=> count[1] == $past(count[0]))
      else $error("capture did not copy core count");

   a_reload_copy: assert property (
      rl_fire[2] && !rl_fire[1] && !sw_cnt_wr[0] |=> count[0] == $past(count[2]))
      else $error("reload did not load core from aux high");

   a_quad_step: assert property (
      g_tmr[2].mode == mtm_pkg::mode_incr && ctrl[2][mtm_pkg::f_run] && !held[2] && qstep[2]
      |-> tick[2] && down[2] == (qdown[2] ^ ctrl[2][mtm_pkg::f_sw_down]))
      else $error("quadrature step not counted");

   a_irq_level: assert property (irq == |(status & mask))
      else $error("interrupt line disagrees with flags");

   c_core_wrap: cover property (wrap[0] ##1 irq);
   c_capture: cover property (cap_fire[1]);
   c_pwm_alt: cover property (rl_fire[1] ##[1:300] rl_fire[2] ##[1:300] rl_fire[1]);
   c_quad_down: cover property (tick[2] && down[2] && g_tmr[2].mode == mtm_pkg::mode_incr);
endmodule

// ==== dv/mtm_pin_model.sv ====
// Pin model: count/gate and direction pins of the three timers
// Assumes calls start just after a rising pclk edge; levels hold 8 clocks
`timescale 1ns/100ps
module mtm_pin_model (
   // Clock
   input wire logic pclk,
   // Timer pins
   output logic [2:0] cg,
   output logic [2:0] dir
);
   initial begin
      cg = 3'h0;
      dir = 3'h0;
   end
   // Twice the pin sampling interval
   task automatic set(input int i, input logic c, input logic d);
      cg[i] <= c;
      dir[i] <= d;
      repeat (8) @(posedge pclk);
   endtask
   task automatic pulse(input int i, input int n);
      repeat (n) begin
         set(i, 1'b1, dir[i]);
         set(i, 1'b0, dir[i]);
      end
   endtask
   // One quadrature step; A leads B when counting up
   task automatic quad(input int i, input bit up);
      logic a;
      logic b;
      a = cg[i];
      b = dir[i];
      if ((a == b) == up) begin
         set(i, !a, b);
      end else begin
         set(i, a, !b);
      end
   endtask
endmodule

// ==== dv/tb.sv ====
// Self-checking bench of the multimode timer module
// Assumes the pin model on the timer pins and a single APB master
`timescale 1ns/100ps
module tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tlp, irq, err, w;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0] cg, dir;
   int error_cnt = 0;
   int comparisons = 0;
   int cyc = 0;
   int t0, e, per, n, m, c1, c2, dn, lat;
   mtm_timer_module dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .timer_count_gate_input(cg),
      .timer_direction_input(dir), .toggle_latch_pin(tlp), .irq(irq));
   mtm_pin_model pins (.pclk(pclk), .cg(cg), .dir(dir));
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   always @(posedge pclk) cyc <= cyc + 1;
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      t0 = cyc;
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // Read whose setup edge falls at a chosen cycle
   task automatic rd_at(input logic [7:0] a, input int t);
      while (cyc < t - 1) @(posedge pclk);
      xfer(1'b0, a, 32'h0);
   endtask
   task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_bit(input logic got, input logic exp);
      cmp_val({31'h0, got}, {31'h0, exp});
   endtask
   task automatic report_and_stop();
      if (error_cnt == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic wait_tl(input logic v);
      while (tlp !== v) @(posedge pclk);
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      error_cnt++;
      report_and_stop();
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, lat} = '0;
      void'($urandom(13));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int a = 0; a < 36; a += 4) begin
         xfer(1'b0, 8'(a), 32'h0);
         cmp_val(rd, 32'h0);
         cmp_bit(err, a == 32);
      end
      // Core up/down by software bit and direction pin, one wrap each
      for (int i = 0; i < 4; i++) begin
         e = $urandom_range(2);
         per = 4 << e;
         dn = (i % 2) ^ (i / 2);
         pins.set(0, 1'b0, 1'(i / 2));
         xfer(1'b1, 8'h1c, 32'(i != 0));
         xfer(1'b1, 8'h0c, dn ? 32'h5 : 32'hfffa);
         xfer(1'b1, 8'h00, 32'(12'h814 | (i % 2) * 8 | e * 256));
         xfer(1'b0, 8'h0c, 32'h0);
         c1 = rd;
         rd_at(8'h0c, t0 + 8 * per);
         cmp_val(rd, 32'((c1 + (dn ? -8 : 8)) & 32'hffff));
         lat ^= 1;
         xfer(1'b0, 8'h18, 32'h0);
         cmp_val(rd, 32'(lat * 32 + 1));
         cmp_bit(tlp, 1'(lat));
         cmp_bit(irq, i != 0);
         xfer(1'b1, 8'h00, 32'h800);
         xfer(1'b1, 8'h18, 32'h1f);
         repeat (2) @(posedge pclk);
         cmp_bit(irq, 1'b0);
      end
      // Gated core: counts only at the active gate level
      xfer(1'b1, 8'h0c, 32'h0);
      xfer(1'b1, 8'h00, 32'h825);
      for (int g = 0; g < 2; g++) begin
         pins.set(0, 1'(g), 1'b0);
         xfer(1'b0, 8'h0c, 32'h0);
         c1 = rd;
         rd_at(8'h0c, t0 + 32);
         cmp_val(rd, 32'(c1 + 8 * g));
      end
      // Aux low counts pin edges, rising then both
      for (int s = 1; s < 4; s += 2) begin
         xfer(1'b1, 8'h10, 32'hffff);
         xfer(1'b1, 8'h04, 32'(6 + s * 64));
         xfer(1'b1, 8'h18, 32'h2);
         n = $urandom_range(5, 1);
         pins.pulse(1, n);
         xfer(1'b0, 8'h10, 32'h0);
         cmp_val(rd, 32'(n * (s == 3 ? 2 : 1) - 1));
         xfer(1'b0, 8'h18, 32'h0);
         cmp_val(rd & 32'h2, 32'h2);
      end
      // Aux high follows quadrature position
      xfer(1'b1, 8'h14, 32'h0);
      xfer(1'b1, 8'h08, 32'h7);
      n = $urandom_range(6, 2);
      m = $urandom_range(9, 0);
      repeat (n) pins.quad(2, 1'b1);
      repeat (m) pins.quad(2, 1'b0);
      xfer(1'b0, 8'h14, 32'h0);
      cmp_val(rd, 32'((n - m) & 32'hffff));
      // Capture of the running core into aux low
      xfer(1'b1, 8'h04, 32'h1040);
      xfer(1'b1, 8'h00, 32'h804);
      xfer(1'b0, 8'h0c, 32'h0);
      c1 = rd;
      pins.pulse(1, 1);
      xfer(1'b0, 8'h0c, 32'h0);
      c2 = rd;
      xfer(1'b0, 8'h10, 32'h0);
      n = rd;
      cmp_bit(n >= c1 && n <= c2, 1'b1);
      xfer(1'b0, 8'h18, 32'h0);
      cmp_val(rd & 32'h8, 32'h8);
      xfer(1'b0, 8'h10, 32'h0);
      cmp_val(rd, 32'(n));
      // Alternating reloads give 16 ticks high, 32 ticks low
      xfer(1'b1, 8'h10, 32'hfff0);
      xfer(1'b1, 8'h14, 32'hffe0);
      xfer(1'b1, 8'h04, 32'h8800);
      xfer(1'b1, 8'h08, 32'h10800);
      xfer(1'b1, 8'h0c, 32'hfffe);
      wait_tl(1'b1);
      c1 = cyc;
      wait_tl(1'b0);
      cmp_val(32'(cyc - c1), 32'd64);
      c1 = cyc;
      wait_tl(1'b1);
      cmp_val(32'(cyc - c1), 32'd128);
      xfer(1'b0, 8'h10, 32'h0);
      cmp_val(rd, 32'hfff0);
      // Aux high counts toggle latch changes
      xfer(1'b1, 8'h04, 32'h18800);
      xfer(1'b1, 8'h14, 32'h0);
      xfer(1'b1, 8'h08, 32'h2006);
      n = $urandom_range(4, 2);
      repeat (n) begin
         w = tlp;
         wait_tl(!w);
      end
      xfer(1'b0, 8'h14, 32'h0);
      cmp_val(rd, 32'(n));
      // Aux low reloads the stopped core on a pin edge
      xfer(1'b1, 8'h00, 32'h800);
      xfer(1'b1, 8'h0c, 32'h0);
      xfer(1'b1, 8'h04, 32'h4840);
      xfer(1'b1, 8'h18, 32'h1f);
      pins.pulse(1, 1);
      xfer(1'b0, 8'h0c, 32'h0);
      cmp_val(rd, 32'hfff0);
      xfer(1'b0, 8'h18, 32'h0);
      cmp_val(rd & 32'h8, 32'h8);
      report_and_stop();
   end
endmodule
